// >>> rx_fmt_pkg.sv
// Purpose: constants and carrier types for the receive output formatter
// Assumes: one channel, 100 MHz reference clock, line clock sampled as a level
// Notes:   the rule summary below is the contract of the formatter
//
// Contract
// RULE1 - single-rail mode drives decoded NRZ receive data on the data output
// RULE2 - single-rail decoding follows AMI or B8ZS/HDB3 by decoder select
// RULE3 - violation flag is high exactly one receive clock cycle per event
// RULE4 - AMI decoder flags bipolar violations only, no code or zeros events
// RULE5 - dual-rail recovered mode: positive rail for positive pulse, negative likewise
// RULE6 - data launched on falling clock edge when edge select low, rising when high
// RULE7 - dual-rail without recovery drives raw unretimed RZ sliced pulses
// RULE8 - data-recovery rails are active low with edge select low, high otherwise
// RULE9 - hardware control mode keeps presenting data during signal loss
// RULE10 - host control mode keeps data or inserts alarm signal by enable bit
// RULE11 - data outputs float while the receiver is powered down
// RULE12 - recovery mode drives the recovered line clock on the clock output
// RULE13 - data-recovery mode drives clock output as XOR of the two rails
// RULE14 - clock output floats while the receiver is powered down
// RULE15 - downstream captures data on the edge opposite to the launch edge
// RULE16 - reference held high selects data-recovery mode with RZ slicing
// RULE17 - reference held low powers receivers down and floats their outputs
// RULE18 - loss indicator high on too few transitions or too low ones density; code counts consecutive zeros only, no ones density
// RULE19 - alarm substitution presents continuous all ones while loss persists

package rx_fmt_pkg;

   // -------------------------------------------------------------------
   // modes and encodings
   // -------------------------------------------------------------------
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_DUAL   = 2'h1;
   localparam logic       DEC_AMI     = 1'h0;
   localparam logic       DEC_HDB3    = 1'h1;
   localparam logic       STD_T1      = 1'h0;  // b8zs substitution
   localparam logic       STD_E1      = 1'h1;  // hdb3 substitution

   // -------------------------------------------------------------------
   // timing and thresholds
   // -------------------------------------------------------------------
   localparam int         SYNC_STAGES    = 2;
   localparam logic [2:0] ZEROS_T1_LIMIT = 3'h7;  // eight zeros is excessive for b8zs
   localparam logic [2:0] ZEROS_E1_LIMIT = 3'h3;  // four zeros is excessive for hdb3
   localparam int         LOSS_WIDTH     = 8;
   localparam logic [7:0] LOSS_LIMIT     = 8'h20; // zero bits before loss declared
   localparam logic [7:0] LOSS_RESET     = 8'h00;
   localparam int         HIST_WIDTH     = 8;
   localparam logic [7:0] HIST_RESET     = 8'h00;

   // -------------------------------------------------------------------
   // status and mask bit positions
   // -------------------------------------------------------------------
   localparam int         EV_VIOL  = 0;
   localparam int         EV_LOSS  = 1;
   localparam int         EV_CLEAR = 2;
   localparam int         EV_WIDTH = 3;

   // -------------------------------------------------------------------
   // register offsets and layouts (plain port, index addressing)
   // -------------------------------------------------------------------
   localparam int         ADDR_WIDTH = 4;
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_MASK   = 4'h2;
   localparam logic [3:0] REG_STATE  = 4'h3;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO  = 8'h00;

   // control register fields
   typedef struct packed
   {
      logic [2:0] spare;
      logic       alarm_insert_enable;  // bit 4
      logic       host_mode;            // bit 3
      logic       std_e1;               // bit 2
      logic       decoder_hdb3;         // bit 1
      logic       dual_rail;            // bit 0
   } ctrl_t;

   // sliced line pulses from the front end
   typedef struct packed
   {
      logic pos;
      logic neg;
   } rails_t;

   // receive outputs with enables
   typedef struct packed
   {
      logic data_a;   // rx_nrz_data or rx_pos_rail
      logic data_b;   // code_violation_flag or rx_neg_rail
      logic clk;      // rx_recovered_clock
      logic oe;       // drive enable of all three
   } rx_pins_t;

endpackage

// >>> rx_line_decoder.sv
// Purpose: single-rail decoder for AMI, B8ZS and HDB3 with violation events
// Assumes: called once per recovered bit with the two retimed rails
// Notes:   output is one bit late so substitutions can be removed

`timescale 1ns/1ps
`default_nettype none

module rx_line_decoder
   import rx_fmt_pkg::*;
(
   // clock and control
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   input  wire logic i_bit_stb,
   input  wire logic i_hdb3,
   input  wire logic i_e1,
   // bit input
   input  wire rails_t i_rails,
   // decoded output
   output logic      o_data,
   output logic      o_viol
);

   // ---------------------------------------------------------------
   // history of marks, polarity and zeros
   // ---------------------------------------------------------------
   logic [HIST_WIDTH-1:0] mark_hist_reg;
   logic [HIST_WIDTH-1:0] mark_hist_next;
   logic                  last_pol_reg;
   logic [2:0]            zeros_reg;
   logic                  data_reg;
   logic                  viol_reg;

   wire mark_now   = i_rails.pos ^ i_rails.neg;
   wire pol_now    = i_rails.pos;
   wire same_pol   = mark_now & (pol_now == last_pol_reg);
   wire code_err   = i_rails.pos & i_rails.neg;
   wire [2:0] zlim = i_e1 ? ZEROS_E1_LIMIT : ZEROS_T1_LIMIT;
   // at or above the limit, so a standard switch in mid-run cannot wrap the count
   wire zero_run   = ~mark_now & (zeros_reg >= zlim);
   // a same-polarity mark inside a zero run is a legal substitution
   wire subst_ok   = i_hdb3 & same_pol & (i_e1 ? (zeros_reg == 3'h2 | zeros_reg == 3'h3)
                                                : (zeros_reg == 3'h3));
   wire bpv        = same_pol & ~subst_ok;                            // [RULE2]
   wire viol_now   = i_hdb3 ? (bpv | code_err | zero_run) : bpv;     // [RULE4]

   assign mark_hist_next = subst_ok ? HIST_RESET
                                    : {mark_hist_reg[HIST_WIDTH-2:0], mark_now};

   // one bit per strobe; flag stands until the next strobe, a whole bit time
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         mark_hist_reg <= HIST_RESET;
         last_pol_reg  <= 1'b0;
         zeros_reg     <= 3'h0;
         data_reg      <= 1'b0;
         viol_reg      <= 1'b0;
      end
      else if (i_ce && i_bit_stb)
      begin
         mark_hist_reg <= mark_hist_next;
         if (mark_now)
            last_pol_reg <= pol_now;
         zeros_reg <= mark_now ? 3'h0 : (zero_run ? zeros_reg : zeros_reg + 3'h1);
         data_reg  <= subst_ok ? 1'b0 : mark_hist_reg[0];                 // [RULE2]
         viol_reg  <= viol_now;                                           // [RULE3]
      end
   end

   assign o_data = data_reg;
   assign o_viol = viol_reg;

endmodule

`default_nettype wire

// >>> rx_channel_output_formatter.sv
// Purpose: receive output stage of one line channel
// Assumes: line clock and sliced rails arrive asynchronously and are synchronised
// Notes:   outputs are registered; the pad ring resolves enables to high-z

`timescale 1ns/1ps
`default_nettype none

module rx_channel_output_formatter
   import rx_fmt_pkg::*;
(
   // clock, reset, enable
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_ce,
   // line side (asynchronous)
   input  wire logic                  i_line_clk,
   input  wire rails_t                i_slice,
   input  wire logic                  i_master_ref_high,
   input  wire logic                  i_master_ref_low,
   input  wire logic                  i_rx_edge_select,
   // register port
   input  wire logic [ADDR_WIDTH-1:0] i_addr,
   input  wire logic [7:0]            i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic      [7:0]            o_rdata,
   // receive pins
   output rx_pins_t                   o_pins,
   output logic                       o_signal_loss,
   output logic                       o_irq
);

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   localparam int SYNC_W = 6;
   logic [SYNC_W-1:0] meta_reg;
   logic [SYNC_W-1:0] sync_reg;
   wire  [SYNC_W-1:0] async_in = {i_master_ref_low, i_master_ref_high, i_rx_edge_select,
                                  i_line_clk, i_slice.pos, i_slice.neg};

   // the first stage is read only by the second
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else if (i_ce)
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   wire s_neg       = sync_reg[0];
   wire s_pos       = sync_reg[1];
   wire s_lclk      = sync_reg[2];
   wire s_edge_sel  = sync_reg[3];
   wire s_ref_high  = sync_reg[4];
   wire s_ref_low   = sync_reg[5];

   // ---------------------------------------------------------------
   // line clock edge detection
   // ---------------------------------------------------------------
   logic lclk_d_reg;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         lclk_d_reg <= 1'b0;
      else if (i_ce)
         lclk_d_reg <= s_lclk;
   end

   wire lclk_rise   = s_lclk & ~lclk_d_reg;
   wire lclk_fall   = ~s_lclk & lclk_d_reg;
   // data launched on the edge chosen by edge select; partner samples the other
   wire launch_edge = s_edge_sel ? lclk_rise : lclk_fall;           // [RULE6] [RULE15]
   // bit sampled mid-cell on the edge opposite the launch edge
   wire sample_edge = s_edge_sel ? lclk_fall : lclk_rise;

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   ctrl_t               ctrl_reg;
   logic [EV_WIDTH-1:0] status_reg;
   logic [EV_WIDTH-1:0] status_next;
   logic [EV_WIDTH-1:0] mask_reg;
   logic [EV_WIDTH-1:0] events;
   logic [7:0]          rdata_reg;
   logic                irq_reg;

   wire wr_ctrl   = i_wr & (i_addr == REG_CTRL);
   wire wr_status = i_wr & (i_addr == REG_STATUS);
   wire wr_mask   = i_wr & (i_addr == REG_MASK);

   // ---------------------------------------------------------------
   // operating mode from reference strap and control
   // ---------------------------------------------------------------
   wire powered_down  = s_ref_low;                                   // [RULE17]
   wire data_recovery = s_ref_high & ~s_ref_low;                     // [RULE16]
   wire single_rail   = ~ctrl_reg.dual_rail & ~data_recovery;

   // ---------------------------------------------------------------
   // bit capture and loss detection
   // ---------------------------------------------------------------
   rails_t           bit_reg;
   logic [LOSS_WIDTH-1:0] zero_cnt_reg;
   logic             loss_reg;
   logic             loss_d_reg;

   wire bit_mark = s_pos | s_neg;
   wire loss_hit = (zero_cnt_reg == LOSS_LIMIT);

   // zeros are counted per bit; any mark ends loss
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         bit_reg      <= '0;
         zero_cnt_reg <= LOSS_RESET;
         loss_reg     <= 1'b0;
         loss_d_reg   <= 1'b0;
      end
      else if (i_ce)
      begin
         loss_d_reg <= loss_reg;
         if (sample_edge)
         begin
            bit_reg.pos  <= s_pos;
            bit_reg.neg  <= s_neg;
            zero_cnt_reg <= bit_mark ? LOSS_RESET
                                     : (loss_hit ? zero_cnt_reg : zero_cnt_reg + 8'h01);
            loss_reg     <= ~bit_mark & (loss_hit | loss_reg);        // [RULE18]
         end
      end
   end

   // ---------------------------------------------------------------
   // single-rail decoder
   // ---------------------------------------------------------------
   logic dec_data;
   logic dec_viol;

   rx_line_decoder u_decoder
   (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_ce      (i_ce),
      .i_bit_stb (launch_edge),
      .i_hdb3    (ctrl_reg.decoder_hdb3),                           // [RULE2]
      .i_e1      (ctrl_reg.std_e1),
      .i_rails   (bit_reg),
      .o_data    (dec_data),
      .o_viol    (dec_viol)
   );

   // ---------------------------------------------------------------
   // output selection
   // ---------------------------------------------------------------
   // alarm substitution only in host mode, only with the enable set
   wire ais_on    = ctrl_reg.host_mode & ctrl_reg.alarm_insert_enable & loss_reg; // [RULE9] [RULE10]
   // raw rails are active low when edge select is low
   wire raw_pos   = s_edge_sel ? s_pos : ~s_pos;                     // [RULE7] [RULE8]
   wire raw_neg   = s_edge_sel ? s_neg : ~s_neg;                     // [RULE8]

   wire sr_a      = ais_on ? 1'b1 : dec_data;                        // [RULE1] [RULE19]
   wire sr_b      = ais_on ? 1'b0 : dec_viol;                        // [RULE3]
   // alarm on dual rail: alternating marks form an all-ones line pattern
   logic ais_alt_reg;
   wire dr_a      = ais_on ? ais_alt_reg : bit_reg.pos;              // [RULE5] [RULE19]
   wire dr_b      = ais_on ? ~ais_alt_reg : bit_reg.neg;             // [RULE5]

   wire sel_a     = data_recovery ? raw_pos : (single_rail ? sr_a : dr_a);
   wire sel_b     = data_recovery ? raw_neg : (single_rail ? sr_b : dr_b);
   // xor clock taken from the true-polarity rails
   wire sel_clk   = data_recovery ? (s_pos ^ s_neg) : s_lclk;        // [RULE12] [RULE13]

   // ---------------------------------------------------------------
   // output registers; retimed data only moves on the launch edge
   // ---------------------------------------------------------------
   rx_pins_t pins_reg;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         pins_reg    <= '0;
         ais_alt_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         pins_reg.oe  <= ~powered_down;                              // [RULE11] [RULE14]
         pins_reg.clk <= powered_down ? 1'b0 : sel_clk;
         if (launch_edge)
            ais_alt_reg <= ~ais_alt_reg;
         if (powered_down)
         begin
            pins_reg.data_a <= 1'b0;
            pins_reg.data_b <= 1'b0;
         end
         else if (data_recovery || launch_edge)                      // [RULE6]
         begin
            pins_reg.data_a <= sel_a;
            pins_reg.data_b <= sel_b;
         end
      end
   end

   // ---------------------------------------------------------------
   // events, status, mask and interrupt
   // ---------------------------------------------------------------
   assign events[EV_VIOL]  = launch_edge & dec_viol & single_rail;
   assign events[EV_LOSS]  = loss_reg & ~loss_d_reg;
   assign events[EV_CLEAR] = ~loss_reg & loss_d_reg;
   // a new event wins over a clear in the same cycle
   assign status_next = (status_reg & ~(wr_status ? i_wdata[EV_WIDTH-1:0] : '0)) | events;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         ctrl_reg   <= CTRL_RESET;
         status_reg <= '0;
         mask_reg   <= '0;
         irq_reg    <= 1'b0;
      end
      else if (i_ce)
      begin
         if (wr_ctrl)
            ctrl_reg <= i_wdata;
         if (wr_mask)
            mask_reg <= i_wdata[EV_WIDTH-1:0];
         status_reg <= status_next;
         irq_reg    <= |(status_next & mask_reg);
      end
   end

   // ---------------------------------------------------------------
   // read port: data in the cycle after the strobe, zero elsewhere
   // ---------------------------------------------------------------
   wire [7:0] rd_mux = (i_addr == REG_CTRL)   ? ctrl_reg :
                       (i_addr == REG_STATUS) ? {5'h00, status_reg} :
                       (i_addr == REG_MASK)   ? {5'h00, mask_reg} :
                       (i_addr == REG_STATE)  ? {4'h0, powered_down, data_recovery,
                                                 single_rail, loss_reg} :
                                                READ_ZERO;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         rdata_reg <= READ_ZERO;
      else if (i_ce)
         rdata_reg <= i_rd ? rd_mux : READ_ZERO;
   end

   assign o_rdata       = rdata_reg;
   assign o_pins        = pins_reg;
   assign o_signal_loss = loss_reg;                                  // [RULE18]
   assign o_irq         = irq_reg;

endmodule

`default_nettype wire

// >>> rx_fmt_monitor.sv
// Purpose: port checker for the receive output formatter
// Assumes: one clock domain, synchronous active-high reset
// Notes:   settle windows of 5 or 6 cycles cover the 3-cycle sync path
`timescale 1ns/1ps
`default_nettype none
module rx_fmt_monitor
   import rx_fmt_pkg::*;
(
   // clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_ce,
   // line side
   input  wire logic                  i_line_clk,
   input  wire rails_t                i_slice,
   input  wire logic                  i_master_ref_high,
   input  wire logic                  i_master_ref_low,
   input  wire logic                  i_rx_edge_select,
   // register port
   input  wire logic [ADDR_WIDTH-1:0] i_addr,
   input  wire logic [7:0]            i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   input  wire logic [7:0]            o_rdata,
   // outputs
   input  wire rx_pins_t              o_pins,
   input  wire logic                  o_signal_loss,
   input  wire logic                  o_irq
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   // ----------------------------------------
   // pin behaviour
   // ----------------------------------------
   AST_PWRDN_FLOAT : assert property (i_master_ref_low [*5] |-> !o_pins.oe)
      else $error("outputs driven while powered down");
   AST_IDLE_ZERO : assert property (!o_pins.oe |-> o_pins == '0)
      else $error("undriven pins not parked low");
   AST_XOR_CLK : assert property ((i_master_ref_high && !i_master_ref_low) [*6]
      |-> o_pins.clk == (o_pins.data_a ^ o_pins.data_b)) else $error("clock not rail xor");
   AST_POL_LOW : assert property ((i_master_ref_high && !i_rx_edge_select
      && !i_master_ref_low && i_slice == 2'h0) [*6] |-> o_pins.data_a && o_pins.data_b)
      else $error("idle rails not high with edge select low");
   AST_POL_HIGH : assert property ((i_master_ref_high && i_rx_edge_select
      && !i_master_ref_low && i_slice == 2'h0) [*6] |-> !o_pins.data_a && !o_pins.data_b)
      else $error("idle rails not low with edge select high");
   // a flag must stand eight reference cycles, most of a bit of about twelve
   AST_VIOL_HOLD : assert property ($rose(o_pins.data_b) && !i_master_ref_high
      |-> (o_pins.data_b || i_master_ref_high || i_master_ref_low) [*8])
      else $error("violation flag shorter than a bit");

   // ----------------------------------------
   // register port
   // ----------------------------------------
   AST_RD_IDLE : assert property (!$past(i_rd) |-> o_rdata == READ_ZERO)
      else $error("read data not zero outside read answer");
   AST_RD_UNMAPPED : assert property ($past(i_rd) && $past(i_addr) > REG_STATE
      |-> o_rdata == READ_ZERO) else $error("unmapped read not zero");
endmodule
bind rx_channel_output_formatter rx_fmt_monitor mon_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
   .i_ce(i_ce), .i_line_clk(i_line_clk), .i_slice(i_slice), .i_master_ref_high(i_master_ref_high),
   .i_master_ref_low(i_master_ref_low), .i_rx_edge_select(i_rx_edge_select), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pins(o_pins),
   .o_signal_loss(o_signal_loss), .o_irq(o_irq));
`default_nettype wire

// >>> rx_framer_model.sv
// Purpose: downstream framer that captures the receive pins
// Assumes: pins are registered in the reference clock domain
// Notes:   counts captured bits and ones on each rail
`timescale 1ns/1ps
`default_nettype none
module rx_framer_model
   import rx_fmt_pkg::*;
(
   // clock and control
   input  wire logic     i_ref_clk,
   input  wire logic     i_clear,
   input  wire logic     i_edge_select,
   input  wire rx_pins_t i_pins,
   // tallies
   output var  int       o_bits,
   output var  int       o_ones_a,
   output var  int       o_ones_b
);
   logic clk_q;
   logic cap;
   // capture on the edge opposite the launch edge, mid-bit where data is stable
   assign cap = i_pins.oe && (i_edge_select ? (clk_q && !i_pins.clk) : (!clk_q && i_pins.clk));
   always_ff @(posedge i_ref_clk)
   begin
      clk_q <= i_pins.clk;
      if (i_clear)
      begin
         o_bits   <= 0;
         o_ones_a <= 0;
         o_ones_b <= 0;
      end
      else if (cap)
      begin
         o_bits   <= o_bits + 1;
         o_ones_a <= o_ones_a + int'(i_pins.data_a);
         o_ones_b <= o_ones_b + int'(i_pins.data_b);
      end
   end
endmodule
`default_nettype wire

// >>> test_rx_channel_output_formatter.sv
// Purpose: self-checking bench for the receive output formatter
// Assumes: line bits of 12 or 13 reference cycles, about 125 ns
// Notes:   line clock stands still between bursts
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_rx_channel_output_formatter;
   import rx_fmt_pkg::*;
   logic       clk = 0;
   logic       rst = 1;
   logic       line_clk = 0;
   rails_t     slice = '0;
   logic       ref_high = 0;
   logic       ref_low = 0;
   logic       esel = 1;
   logic [3:0] addr = '0;
   logic [7:0] wdata = '0;
   logic       wr = 0;
   logic       rd = 0;
   logic [7:0] rdata;
   rx_pins_t   pins;
   logic       loss;
   logic       irq;
   logic       clr = 0;
   logic       pol = 1;
   int         nb = 0;
   int         bits, ones_a, ones_b, cyc = 0, n_fail = 0, n_checks = 0;

   rx_channel_output_formatter dut_u (.i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1),
      .i_line_clk(line_clk), .i_slice(slice), .i_master_ref_high(ref_high),
      .i_master_ref_low(ref_low), .i_rx_edge_select(esel), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_pins(pins), .o_signal_loss(loss), .o_irq(irq));
   rx_framer_model far_u (.i_ref_clk(clk), .i_clear(clr), .i_edge_select(esel), .i_pins(pins),
      .o_bits(bits), .o_ones_a(ones_a), .o_ones_b(ones_b));

   // clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         test_done();
      end
   end

   // ----------------------------------------
   // bus and line tasks
   // ----------------------------------------
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rreg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1; addr <= a;
      @(posedge clk);
      rd <= 0;
      #1 d = rdata;
   endtask
   // rail pulse straddles the sampling line edge; edge select low inverts the line clock
   task automatic sbit(input logic p, input logic n);
      for (int k = 0; k < 12 + (nb % 2); k++)
      begin
         @(posedge clk);
         line_clk <= ((k < 6) == esel);
         slice    <= {p && k > 0 && k < 9, n && k > 0 && k < 9};
      end
      nb++;
   endtask
   task automatic zeros(input int n);
      repeat (n) sbit(0, 0);
   endtask
   task automatic mark();
      sbit(pol, !pol);
      pol = !pol;
   endtask
   task automatic clear_far();
      @(posedge clk) clr <= 1;
      @(posedge clk) clr <= 0;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [7:0] d;
      rreg(REG_CTRL, d);  `CHK(d, CTRL_RESET)
      wreg(REG_CTRL, 8'h15);
      rreg(REG_CTRL, d);  `CHK(d, 8'h15)
      wreg(4'h9, 8'hff);
      rreg(4'h9, d);      `CHK(d, READ_ZERO)
   endtask
   task automatic t_single();
      logic [7:0] d;
      wreg(REG_CTRL, 8'h00);
      clear_far(); zeros(9); repeat (6) mark(); zeros(4);
      `CHK(ones_a, 6)
      `CHK(ones_b, 0)
      clear_far(); mark(); sbit(!pol, pol); zeros(4);
      `CHK(ones_b, 1)
      rreg(REG_STATUS, d); `CHK(d[EV_VIOL], 1'h1)
      // irq uses the new mask one cycle after the mask write lands
      wreg(REG_MASK, 8'h01); @(posedge clk); #1 `CHK(irq, 1'h1)
      wreg(REG_STATUS, 8'h01); @(posedge clk); #1 `CHK(irq, 1'h0)
      wreg(REG_CTRL, 8'h06);
      clear_far(); mark(); zeros(6); mark(); zeros(4);
      `CHK(ones_b != 0, 1'b1)
   endtask
   task automatic t_loss();
      logic [7:0] d;
      wreg(REG_CTRL, 8'h00);
      zeros(40); `CHK(loss, 1'h1)
      clear_far(); zeros(8); `CHK(ones_a, 0)
      wreg(REG_CTRL, 8'h18);
      clear_far(); zeros(8); `CHK(ones_a, 8)
      `CHK(bits, 8)
      wreg(REG_CTRL, 8'h08);
      clear_far(); zeros(8); `CHK(ones_a, 0)
      repeat (3) mark(); zeros(2); `CHK(loss, 1'h0)
      rreg(REG_STATUS, d); `CHK(d[2:1], 2'h3)
      wreg(REG_STATUS, 8'h07);
   endtask
   task automatic t_dual();
      wreg(REG_CTRL, 8'h01);
      clear_far(); zeros(2); sbit(1, 0); sbit(0, 1); zeros(3);
      `CHK(ones_a, 1)
      `CHK(ones_b, 1)
      `CHK(bits, 7)
      // edge select low: launch on the falling line edge, capture on the rising one
      esel <= 0;
      clear_far(); zeros(1); sbit(1, 0); zeros(2);
      `CHK(ones_a, 1)
      `CHK(ones_b, 0)
      `CHK(bits, 4)
   endtask
   task automatic t_raw();
      logic [7:0] d;
      ref_high <= 1; esel <= 0; repeat (8) @(posedge clk);
      #1 `CHK({pins.data_a, pins.data_b}, 2'h3)
      @(posedge clk) slice <= 2'h2; repeat (8) @(posedge clk);
      #1 `CHK({pins.data_a, pins.data_b, pins.clk}, 3'h3)
      @(posedge clk) esel <= 1; repeat (8) @(posedge clk);
      #1 `CHK({pins.data_a, pins.data_b, pins.clk}, 3'h5)
      rreg(REG_STATE, d); `CHK(d[2], 1'h1)
      @(posedge clk) slice <= 2'h0;
      repeat (8) @(posedge clk);
      #1 `CHK({pins.data_a, pins.data_b, pins.clk}, 3'h0)
      @(posedge clk) ref_low <= 1;
      repeat (8) @(posedge clk);
      #1 `CHK(pins, 4'h0)
      rreg(REG_STATE, d); `CHK(d[3], 1'h1)
   endtask

   task automatic test_done();
      if (n_fail == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 0;
      repeat (4) @(posedge clk);
      t_regs(); t_single(); t_loss(); t_dual(); t_raw();
      test_done();
   end
endmodule
`default_nettype wire
